//--- uart_isr_lcr_consts.svh
`ifndef UART_ISR_LCR_CONSTS_SVH
`define UART_ISR_LCR_CONSTS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_STATUS 3'h2
`define OFS_FIFO_CTRL 3'h2
`define OFS_ENH 3'h2
`define OFS_LINE_FMT 3'h3
// ------------------------------------------------------------
// field positions and resets
// ------------------------------------------------------------
`define FMT_DIV_ACCESS 7
`define FMT_BREAK 6
`define FMT_STICK 5
`define FMT_EVEN 4
`define FMT_PAR_EN 3
`define FMT_STOP 2
`define FMT_LEN_HI 1
`define FMT_LEN_LO 0
`define FIFO_CTRL_EN 0
`define ENH_FEATURE_BIT 4
`define FMT_RESET 8'h00
`define FIFO_EN_RESET 1'b0
`define TX_IDLE 1'b1
`define WORD_BITS_MIN 4'h5
`define STATUS_IDLE 8'h01
// ------------------------------------------------------------
// interrupt codes, bits 5:0
// ------------------------------------------------------------
`define CODE_LINE 6'h06
`define CODE_RX_DATA 6'h04
`define CODE_RXTO 6'h0C
`define CODE_THRE 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF 6'h10
`define CODE_FLOW 6'h20
`endif

//--- uart_isr_lcr_pkg.sv
package uart_isr_lcr_pkg;
  typedef enum logic [4:0] {
    PAR_NONE = 5'h01,
    PAR_ODD = 5'h02,
    PAR_EVEN = 5'h04,
    PAR_ONE = 5'h08,
    PAR_ZERO = 5'h10
  } parity_t;

  typedef struct packed {
    logic line_err;
    logic rx_ready;
    logic rx_timeout;
    logic thr_empty;
    logic modem_chg;
    logic xoff_det;
    logic xon_det;
    logic flow_chg;
  } irq_src_t;

  typedef struct packed {
    logic [1:0] cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [7:0] line_fmt;
    logic fifo_en;
    logic enh;
    logic xoff;
    logic flow;
    logic tx;
    logic [3:0] word_bits;
    logic stop_half;
    logic stop_two;
    parity_t parity;
  } chan_t;

  typedef struct packed {
    chan_t [1:0] ch;
    logic [7:0] rdata;
  } state_t;
endpackage

//--- uart_isr_lcr.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_isr_lcr_consts.svh"
module uart_isr_lcr (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire uart_isr_lcr_pkg::host_req_t i_host,
  input wire uart_isr_lcr_pkg::irq_src_t [1:0] i_src,
  input wire logic [1:0] i_tx_serial,
  output logic [7:0] o_rdata,
  output logic [1:0] o_tx,
  output logic [1:0][3:0] o_word_bits,
  output logic [1:0] o_stop_half,
  output logic [1:0] o_stop_two,
  output var uart_isr_lcr_pkg::parity_t [1:0] o_parity,
  output logic [1:0] o_fifo_en,
  output logic [1:0] o_divisor_access
);

  // ------------------------------------------------------------
  // host decode
  // ------------------------------------------------------------
  // both selects high reach channel 0 only, so one access never lands twice
  function automatic logic chan_hit(input logic [1:0] cs, input int c);
    logic hit;
    hit = 1'b0;
    if (c == 0) begin
      hit = cs[0];
    end else begin
      hit = cs[1] && !cs[0];
    end
    return hit;
  endfunction

  // offset 2 is shared: status and fifo control while bit 7 is clear
  function automatic logic at_status(input logic [2:0] addr, input logic [7:0] fmt);
    logic hit;
    hit = 1'b0;
    if (addr == `OFS_STATUS && !fmt[`FMT_DIV_ACCESS]) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // the same offset reaches the enhanced register while bit 7 is set
  function automatic logic at_enh(input logic [2:0] addr, input logic [7:0] fmt);
    logic hit;
    hit = 1'b0;
    if (addr == `OFS_ENH && fmt[`FMT_DIV_ACCESS]) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic at_fifo_ctrl(input logic [2:0] addr, input logic [7:0] fmt);
    logic hit;
    hit = 1'b0;
    if (addr == `OFS_FIFO_CTRL && !fmt[`FMT_DIV_ACCESS]) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic at_line_fmt(input logic [2:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == `OFS_LINE_FMT) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // ------------------------------------------------------------
  // priority encoder
  // ------------------------------------------------------------
  // bit 6 flags pending; only the winner is shown so software services one at a time
  function automatic logic [6:0] pick_code(input uart_isr_lcr_pkg::irq_src_t s, input logic xoff,
                                           input logic flow, input logic enh);
    logic [6:0] code;
    code = 7'h00;
    if (s.line_err) begin
      code = {1'b1, `CODE_LINE};
    end else if (s.rx_timeout) begin
      code = {1'b1, `CODE_RXTO};
    end else if (s.rx_ready) begin
      code = {1'b1, `CODE_RX_DATA};
    end else if (s.thr_empty) begin
      code = {1'b1, `CODE_THRE};
    end else if (s.modem_chg) begin
      code = {1'b1, `CODE_MODEM};
    end else if (enh && xoff) begin
      code = {1'b1, `CODE_XOFF};
    end else if (enh && flow) begin
      code = {1'b1, `CODE_FLOW};
    end
    return code;
  endfunction

  // top pair mirrors the fifo enable; bit 0 reads high only when nothing is pending
  function automatic logic [7:0] status_byte(input logic [6:0] code, input logic fifo_en);
    logic [7:0] b;
    b = {{2{fifo_en}}, code[5:0]};
    if (!code[6]) begin
      b = b | `STATUS_IDLE;
    end
    return b;
  endfunction

  // xon clears the xoff flag, but a fresh xoff in the same cycle wins
  function automatic logic next_xoff(input logic cur, input uart_isr_lcr_pkg::irq_src_t s);
    logic f;
    f = cur;
    if (s.xon_det) begin
      f = 1'b0;
    end
    if (s.xoff_det) begin
      f = 1'b1;
    end
    return f;
  endfunction

  // the status read that reports a flow change services it; a new change wins
  function automatic logic next_flow(input logic cur, input uart_isr_lcr_pkg::irq_src_t s, input logic seen);
    logic f;
    f = cur;
    if (seen) begin
      f = 1'b0;
    end
    if (s.flow_chg) begin
      f = 1'b1;
    end
    return f;
  endfunction

  // ------------------------------------------------------------
  // line format decode
  // ------------------------------------------------------------
  function automatic logic [3:0] fmt_word_bits(input logic [7:0] fmt);
    logic [3:0] n;
    n = `WORD_BITS_MIN + {2'h0, fmt[`FMT_LEN_HI:`FMT_LEN_LO]};
    return n;
  endfunction

  // a 5-bit character gets one and a half stop bits instead of two
  function automatic logic fmt_stop_half(input logic [7:0] fmt);
    logic r;
    r = fmt[`FMT_STOP] && fmt[`FMT_LEN_HI:`FMT_LEN_LO] == 2'h0;
    return r;
  endfunction

  function automatic logic fmt_stop_two(input logic [7:0] fmt);
    logic r;
    r = fmt[`FMT_STOP] && fmt[`FMT_LEN_HI:`FMT_LEN_LO] != 2'h0;
    return r;
  endfunction

  // 001 stays odd parity; force-one takes 101 so the two never overlap
  function automatic uart_isr_lcr_pkg::parity_t decode_parity(input logic [7:0] fmt);
    uart_isr_lcr_pkg::parity_t p;
    p = uart_isr_lcr_pkg::PAR_NONE;
    if (!fmt[`FMT_PAR_EN]) begin
      p = uart_isr_lcr_pkg::PAR_NONE;
    end else if (!fmt[`FMT_EVEN] && !fmt[`FMT_STICK]) begin
      p = uart_isr_lcr_pkg::PAR_ODD;
    end else if (!fmt[`FMT_EVEN]) begin
      p = uart_isr_lcr_pkg::PAR_ONE;
    end else if (!fmt[`FMT_STICK]) begin
      p = uart_isr_lcr_pkg::PAR_EVEN;
    end else begin
      p = uart_isr_lcr_pkg::PAR_ZERO;
    end
    return p;
  endfunction

  // break overrides serial data and holds until software clears the bit
  function automatic logic tx_level(input logic serial, input logic [7:0] fmt);
    logic lvl;
    lvl = serial;
    if (fmt[`FMT_BREAK]) begin
      lvl = 1'b0;
    end
    return lvl;
  endfunction

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  // unmapped offsets read zero; there is no error indication on the host side
  function automatic logic [7:0] read_mux(input logic [2:0] addr, input uart_isr_lcr_pkg::chan_t ch,
                                          input logic [6:0] code);
    logic [7:0] b;
    b = 8'h00;
    if (at_line_fmt(addr)) begin
      b = ch.line_fmt;
    end else if (at_enh(addr, ch.line_fmt)) begin
      b = {3'h0, ch.enh, 4'h0};
    end else if (at_status(addr, ch.line_fmt)) begin
      b = status_byte(code, ch.fifo_en);
    end
    return b;
  endfunction

  // the enhanced register hides behind bit 7, so a cleared bit 7 lands on fifo control
  function automatic uart_isr_lcr_pkg::chan_t write_reg(input uart_isr_lcr_pkg::chan_t ch,
                                                        input logic [2:0] addr, input logic [7:0] wdata);
    uart_isr_lcr_pkg::chan_t n;
    n = ch;
    if (at_line_fmt(addr)) begin
      n.line_fmt = wdata;
    end else if (at_enh(addr, ch.line_fmt)) begin
      n.enh = wdata[`ENH_FEATURE_BIT];
    end else if (at_fifo_ctrl(addr, ch.line_fmt)) begin
      n.fifo_en = wdata[`FIFO_CTRL_EN];
    end
    return n;
  endfunction

  // format outputs follow the register on the same edge as the write, decoded from the new value
  function automatic uart_isr_lcr_pkg::chan_t drive_format(input uart_isr_lcr_pkg::chan_t ch,
                                                           input logic serial);
    uart_isr_lcr_pkg::chan_t n;
    n = ch;
    n.tx = tx_level(serial, ch.line_fmt);
    n.word_bits = fmt_word_bits(ch.line_fmt);
    n.stop_half = fmt_stop_half(ch.line_fmt);
    n.stop_two = fmt_stop_two(ch.line_fmt);
    n.parity = decode_parity(ch.line_fmt);
    return n;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  uart_isr_lcr_pkg::state_t s_q;
  uart_isr_lcr_pkg::state_t s_d;

  always_comb begin
    logic [6:0] code;
    logic sel;
    logic seen;
    code = 7'h00;
    sel = 1'b0;
    seen = 1'b0;
    s_d = s_q;
    // read data stands one cycle, then falls back to zero
    s_d.rdata = 8'h00;
    for (int c = 0; c < 2; c++) begin
      sel = chan_hit(i_host.cs, c);
      code = pick_code(i_src[c], s_q.ch[c].xoff, s_q.ch[c].flow, s_q.ch[c].enh);
      seen = sel && i_host.rd && at_status(i_host.addr, s_q.ch[c].line_fmt) && code == {1'b1, `CODE_FLOW};
      s_d.ch[c].xoff = next_xoff(s_q.ch[c].xoff, i_src[c]);
      s_d.ch[c].flow = next_flow(s_q.ch[c].flow, i_src[c], seen);
      if (sel && i_host.rd) begin
        s_d.rdata = read_mux(i_host.addr, s_q.ch[c], code);
      end
      if (sel && i_host.wr) begin
        s_d.ch[c] = write_reg(s_d.ch[c], i_host.addr, i_host.wdata);
      end
      s_d.ch[c] = drive_format(s_d.ch[c], i_tx_serial[c]);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int c = 0; c < 2; c++) begin
        s_q.ch[c].line_fmt <= `FMT_RESET;
        s_q.ch[c].fifo_en <= `FIFO_EN_RESET;
        s_q.ch[c].enh <= 1'b0;
        s_q.ch[c].xoff <= 1'b0;
        s_q.ch[c].flow <= 1'b0;
        s_q.ch[c].tx <= `TX_IDLE;
        s_q.ch[c].word_bits <= `WORD_BITS_MIN;
        s_q.ch[c].stop_half <= 1'b0;
        s_q.ch[c].stop_two <= 1'b0;
        s_q.ch[c].parity <= uart_isr_lcr_pkg::PAR_NONE;
      end
      s_q.rdata <= 8'h00;
    end else if (i_ce) begin
      // a low enable freezes every flag and register, host strobes included
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a register bit, never a path through the decode
  assign o_rdata = s_q.rdata;

  for (genvar c = 0; c < 2; c++) begin : g_out
    assign o_tx[c] = s_q.ch[c].tx;
    assign o_word_bits[c] = s_q.ch[c].word_bits;
    assign o_stop_half[c] = s_q.ch[c].stop_half;
    assign o_stop_two[c] = s_q.ch[c].stop_two;
    assign o_parity[c] = s_q.ch[c].parity;
    assign o_fifo_en[c] = s_q.ch[c].fifo_en;
    assign o_divisor_access[c] = s_q.ch[c].line_fmt[`FMT_DIV_ACCESS];
  end

endmodule // uart_isr_lcr
`default_nettype wire

//--- uart_isr_lcr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uart_isr_lcr_properties (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire uart_isr_lcr_pkg::host_req_t i_host,
  input wire uart_isr_lcr_pkg::irq_src_t [1:0] i_src,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_tx,
  input wire logic [1:0][3:0] o_word_bits,
  input wire logic [1:0] o_stop_half,
  input wire logic [1:0] o_stop_two,
  input wire uart_isr_lcr_pkg::parity_t [1:0] o_parity,
  input wire logic [1:0] o_fifo_en,
  input wire logic [1:0] o_divisor_access
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic wl = i_ce && i_host.wr && i_host.cs == 2'h1 && i_host.addr == 3'h3;
  wire logic rs = i_ce && i_host.rd && i_host.cs == 2'h1 && i_host.addr == 3'h2 && !o_divisor_access[0];
  // last line format byte written to channel 0, so the outputs can be judged two cycles later
  logic [7:0] lw_q;
  always_ff @(posedge i_ref_clk) if (wl) lw_q <= i_host.wdata;
  sequence fmt_set;
    wl ##1 (i_ce && !wl);
  endsequence
  chk_word_len: assert property (fmt_set |=> o_word_bits[0] == 4'h5 + {2'h0, lw_q[1:0]})
    else $error("word length differs from written field");
  chk_stop_sel: assert property (fmt_set |=> o_stop_two[0] == (lw_q[2] && lw_q[1:0] != 2'h0)
    && o_stop_half[0] == (lw_q[2] && lw_q[1:0] == 2'h0)) else $error("stop bit select wrong");
  chk_break_low: assert property (fmt_set |=> !lw_q[6] || !o_tx[0]) else $error("break not low");
  chk_div_bit: assert property (fmt_set |=> o_divisor_access[0] == lw_q[7]) else $error("divisor access");
  chk_par_none: assert property (fmt_set |=> lw_q[3] || o_parity[0] == uart_isr_lcr_pkg::PAR_NONE)
    else $error("parity not none");
  chk_rd_idle: assert property (i_ce && !i_host.rd |=> o_rdata == 8'h00) else $error("read data left");
  chk_line_first: assert property (rs && i_src[0].line_err |=> o_rdata[5:0] == 6'h06)
    else $error("line status not first");
  chk_fifo_bits: assert property (rs |=> o_rdata[7:6] == {2{o_fifo_en[0]}}) else $error("fifo bits");
  chk_reset_out: assert property (disable iff (1'b0) i_rst |=> o_tx == 2'h3 && o_rdata == 8'h00)
    else $error("reset outputs wrong");
endmodule // uart_isr_lcr_properties
bind uart_isr_lcr uart_isr_lcr_properties u_chk (.i_ref_clk, .i_rst, .i_ce, .i_host, .i_src, .o_rdata, .o_tx,
  .o_word_bits, .o_stop_half, .o_stop_two, .o_parity, .o_fifo_en, .o_divisor_access);
`default_nettype wire

//--- remote_station.sv
`timescale 1ns/1ps
`default_nettype none
module remote_station (
  input wire logic i_ref_clk,
  input wire logic i_line,
  output logic o_break
);
  // a short low is a start bit; only a long low run counts as break
  logic [3:0] low_q = 4'h0;
  always_ff @(posedge i_ref_clk) low_q <= i_line ? 4'h0 : low_q + {3'h0, low_q != 4'hF};
  assign o_break = low_q >= 4'hA;
endmodule // remote_station
`default_nettype wire

//--- uart_isr_lcr_test.sv
`timescale 1ns/1ps
`default_nettype none
module uart_isr_lcr_test;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] ser = 2'h3;
  uart_isr_lcr_pkg::host_req_t h = '0;
  uart_isr_lcr_pkg::irq_src_t [1:0] s = '0;
  wire logic [7:0] rd;
  wire logic [1:0] tx, brk, sh, st, fe, da;
  wire logic [1:0][3:0] wb;
  wire uart_isr_lcr_pkg::parity_t [1:0] par;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] pf [5] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38};
  logic [7:0] ptab [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
  logic [7:0] stab [6] = '{8'hF8, 8'h78, 8'h58, 8'h18, 8'h08, 8'h00};
  logic [7:0] ctab [6] = '{8'h06, 8'h0C, 8'h04, 8'h02, 8'h00, 8'h01};
  always #50 i_ref_clk = ~i_ref_clk;
  uart_isr_lcr u_dut (.i_ref_clk, .i_rst, .i_ce(ce), .i_host(h), .i_src(s), .i_tx_serial(ser), .o_rdata(rd),
    .o_tx(tx), .o_word_bits(wb), .o_stop_half(sh), .o_stop_two(st), .o_parity(par), .o_fifo_en(fe),
    .o_divisor_access(da));
  remote_station u_rs0 (.i_ref_clk, .i_line(tx[0]), .o_break(brk[0]));
  remote_station u_rs1 (.i_ref_clk, .i_line(tx[1]), .o_break(brk[1]));
  // ----------------------------------------
  // host access
  // ----------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access, then an idle cycle so format outputs have settled on return
  task automatic acc(input logic [1:0] c, input logic w, input logic [2:0] a, input logic [7:0] d,
    input logic [7:0] e);
    @(negedge i_ref_clk);
    h = '{cs: c, rd: !w, wr: w, addr: a, wdata: d};
    @(negedge i_ref_clk);
    h = '0;
    if (!w) cmp(rd, e);
    @(negedge i_ref_clk);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(negedge i_ref_clk);
    s[0] = v;
    @(negedge i_ref_clk);
    s[0] = '0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge i_ref_clk);
    i_rst = 1'b0;
    cmp({6'h0, tx}, 8'h03);
    acc(2'h1, 0, 3'h2, 0, 8'h01);
    acc(2'h1, 0, 3'h3, 0, 8'h00);
    acc(2'h1, 0, 3'h0, 0, 8'h00);
    ce = 1'b0;
    acc(2'h1, 1, 3'h3, 8'h03, 0);
    ce = 1'b1;
    cmp({4'h0, wb[0]}, 8'h05);
    for (int i = 0; i < 4; i++) begin
      acc(2'h1, 1, 3'h3, 8'h04 | i[7:0], 0);
      cmp({wb[0], 2'h0, sh[0], st[0]}, {4'h5 + i[3:0], 2'h0, i == 0, i != 0});
    end
    cmp({4'h0, wb[1]}, 8'h05);
    for (int i = 0; i < 5; i++) begin
      acc(2'h1, 1, 3'h3, pf[i], 0);
      cmp({3'h0, par[0]}, ptab[i]);
    end
    acc(2'h1, 1, 3'h3, 8'h40, 0);
    repeat (12) @(negedge i_ref_clk);
    cmp({4'h0, tx, brk}, 8'h09);
    acc(2'h1, 1, 3'h3, 8'h00, 0);
    cmp({6'h0, tx}, 8'h03);
    ser = 2'h2;
    @(negedge i_ref_clk);
    cmp({6'h0, tx}, 8'h02);
    ser = 2'h3;
    for (int i = 0; i < 6; i++) begin
      s[0] = stab[i];
      acc(2'h1, 0, 3'h2, 0, ctab[i]);
    end
    acc(2'h1, 1, 3'h2, 8'h01, 0);
    cmp({6'h0, fe}, 8'h01);
    acc(2'h1, 0, 3'h2, 0, 8'hC1);
    acc(2'h2, 0, 3'h2, 0, 8'h01);
    acc(2'h1, 1, 3'h3, 8'h80, 0);
    cmp({6'h0, da}, 8'h01);
    acc(2'h1, 1, 3'h2, 8'h10, 0);
    acc(2'h1, 0, 3'h2, 0, 8'h10);
    acc(2'h1, 1, 3'h3, 8'h00, 0);
    pulse(8'h04);
    acc(2'h1, 0, 3'h2, 0, 8'hD0);
    acc(2'h1, 0, 3'h2, 0, 8'hD0);
    pulse(8'h02);
    acc(2'h1, 0, 3'h2, 0, 8'hC1);
    pulse(8'h01);
    acc(2'h1, 0, 3'h2, 0, 8'hE0);
    acc(2'h1, 0, 3'h2, 0, 8'hC1);
    summarize();
  end
endmodule // uart_isr_lcr_test
`default_nettype wire
